// [design/scrcc_pkg.sv]
/*
 * Constants and state types for the two-channel serial controller register bank.
 * Assumes one 40 MHz clock and a host bus that is synchronous to it.
 */
package scrcc_pkg;
	// write register indices
	localparam logic [3:0] W_CMD = 4'h0;
	localparam logic [3:0] W_VECTOR = 4'h2;
	localparam logic [3:0] W_RXCTL = 4'h3;
	localparam logic [3:0] W_MODE = 4'h4;
	localparam logic [3:0] W_TXCTL = 4'h5;
	localparam logic [3:0] W_PRIME = 4'h7;
	localparam logic [3:0] W_MASTER = 4'h9;
	localparam logic [3:0] W_MISC = 4'ha;
	localparam logic [3:0] W_TCLO = 4'hc;
	localparam logic [3:0] W_TCHI = 4'hd;
	localparam logic [3:0] W_EXTEN = 4'hf;
	// read register indices
	localparam logic [3:0] R_STAT = 4'h0;
	localparam logic [3:0] R_SPEC = 4'h1;
	localparam logic [3:0] R_VEC = 4'h2;
	localparam logic [3:0] R_PEND = 4'h3;
	localparam logic [3:0] R_MODE_RB = 4'h4;
	localparam logic [3:0] R_TXCTL_RB = 4'h5;
	localparam logic [3:0] R_FCNT_LO = 4'h6;
	localparam logic [3:0] R_FCNT_HI = 4'h7;
	localparam logic [3:0] R_RXDATA = 4'h8;
	localparam logic [3:0] R_RXCTL_RB = 4'h9;
	localparam logic [3:0] R_MISC_RB = 4'hb;
	localparam logic [3:0] R_TCLO = 4'hc;
	localparam logic [3:0] R_TCHI = 4'hd;
	localparam logic [3:0] R_PRIME_RB = 4'he;
	localparam logic [3:0] R_EXTEN_RB = 4'hf;
	// command and master reset register fields and codes
	localparam logic [1:0] CRC_NULL = 2'h0;
	localparam logic [1:0] CRC_RX_RST = 2'h1;
	localparam logic [1:0] CRC_TX_RST = 2'h2;
	localparam logic [1:0] CRC_EOM_RST = 2'h3;
	localparam logic [2:0] CMD_POINT_HIGH = 3'h1;
	localparam logic [2:0] CMD_EXT_RST = 3'h2;
	localparam logic [2:0] CMD_SEND_ABORT = 3'h3;
	localparam logic [1:0] MRST_CH_B = 2'h1;
	localparam logic [1:0] MRST_CH_A = 2'h2;
	localparam logic [1:0] MRST_HW = 2'h3;
	// bit positions, mode and vector status codes, channel indices
	localparam int RXEN_BIT = 0;
	localparam int TXEN_BIT = 3;
	localparam int MODE_LSB = 4;
	localparam logic [1:0] MODE_SDLC = 2'h2;
	localparam int ABORT_UR_BIT = 2;
	localparam int FIFO_EN_BIT = 2;
	localparam int PRIME_SEL_BIT = 0;
	localparam int AUTO_EOM_BIT = 1;
	localparam int EXT_READ_BIT = 6;
	localparam int ST_RXAV = 0;
	localparam int ST_TXEMPTY = 2;
	localparam int ST_DCD = 3;
	localparam int ST_CTS = 5;
	localparam int ST_EOM = 6;
	localparam int ST_BREAK = 7;
	localparam logic [2:0] VSTAT_A_EXT = 3'h5;
	localparam logic [2:0] VSTAT_B_EXT = 3'h1;
	localparam logic [2:0] VSTAT_NONE = 3'h3;
	localparam int CH_A = 1;
	localparam int CH_B = 0;
	// reset values and crc
	localparam logic [7:0] RST_REG8 = 8'h00;
	localparam logic RST_EOM_LATCH = 1'b1;
	localparam logic [15:0] CRC_PRESET = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'h1021;

	typedef struct packed {
		logic [3:0] ptr;
		logic [7:0] wr3;
		logic [7:0] wr4;
		logic [7:0] wr5;
		logic [7:0] wr10;
		logic [7:0] wr12;
		logic [7:0] wr13;
		logic [7:0] wr15;
		logic [7:0] efr;
		logic [15:0] rx_crc;
		logic [15:0] tx_crc;
		logic eom_latch;
		logic eom_shown_clr;
		logic ext_pend;
		logic [2:0] ext_lat;
		logic append_crc;
		logic send_abort;
	} scrcc_chan_s;

	typedef struct packed {
		scrcc_chan_s [1:0] ch;
		logic [7:0] vector;
		logic [7:0] master;
		logic [7:0] rdata;
		logic rvalid;
	} scrcc_state_s;
endpackage

// [design/scrcc_regs.sv]
/*
 * Register bank, command decode and crc/end-of-message control for two channels.
 * Assumes the host bus and all datapath inputs are synchronous to mclk.
 */
`timescale 1ns/1ps
module scrcc_regs
	import scrcc_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// host register port
	input wire logic host_cs,
	input wire logic host_chan_a,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [7:0] host_wdata,
	output logic [7:0] host_rdata,
	output logic host_rdata_valid,
	// datapath status, index 1 is channel A
	input wire logic [1:0] rx_bit_vld,
	input wire logic [1:0] rx_bit,
	input wire logic [1:0] tx_bit_vld,
	input wire logic [1:0] tx_bit,
	input wire logic [1:0] tx_underrun,
	input wire logic [1:0] tx_crc_done,
	input wire logic [1:0] sdlc_frame_end,
	input wire logic [1:0] rx_char_avail,
	input wire logic [1:0] tx_buf_empty,
	input wire logic [1:0] rx_ip,
	input wire logic [1:0] tx_ip,
	input wire logic [1:0][2:0] ext_in,
	input wire logic [1:0][7:0] rx_data,
	input wire logic [1:0][7:0] spec_status,
	input wire logic [1:0][13:0] fifo_count,
	input wire logic [1:0][1:0] fifo_flags,
	// datapath control
	output logic [1:0] append_crc,
	output logic [1:0] send_abort,
	output logic [1:0] ext_irq,
	output logic [1:0][15:0] rx_crc,
	output logic [1:0][15:0] tx_crc
);
	scrcc_state_s s_reg;
	scrcc_state_s s_next;
	logic do_wr;
	logic do_rd;
	logic [3:0] sp;
	logic mres;

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
		logic fb;
		fb = c[15] ^ b;
		crc_step = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
	endfunction

	function automatic scrcc_chan_s chan_init(input scrcc_chan_s cur, input logic keep_tx);
		scrcc_chan_s r;
		r = '0;
		r.wr3 = RST_REG8;
		r.wr4 = RST_REG8;
		r.wr5 = RST_REG8;
		r.wr10 = RST_REG8;
		r.wr12 = RST_REG8;
		r.wr13 = RST_REG8;
		r.wr15 = RST_REG8;
		r.efr = RST_REG8;
		r.rx_crc = CRC_PRESET;
		r.tx_crc = keep_tx ? cur.tx_crc : CRC_PRESET;
		r.eom_latch = RST_EOM_LATCH;
		r.ext_lat = cur.ext_lat;
		chan_init = r;
	endfunction

	function automatic logic is_sdlc(input scrcc_chan_s c);
		is_sdlc = c.wr4[MODE_LSB +: 2] == MODE_SDLC;
	endfunction

	assign do_wr = host_cs & host_wr;
	assign do_rd = host_cs & host_rd & ~host_wr;
	assign sp = s_reg.ch[host_chan_a].ptr;
	assign mres = do_wr && sp == W_MASTER;

	always_comb
	begin
		scrcc_chan_s rc;
		scrcc_chan_s c;
		logic wc;
		logic cmd;
		logic ch_rst;
		logic [2:0] vcode;
		rc = s_reg.ch[host_chan_a];
		c = '0;
		wc = 1'b0;
		cmd = 1'b0;
		ch_rst = 1'b0;
		vcode = VSTAT_NONE;
		s_next = s_reg;
		s_next.rvalid = do_rd;
		if (s_reg.ch[CH_A].ext_pend)
			vcode = VSTAT_A_EXT;
		else if (s_reg.ch[CH_B].ext_pend)
			vcode = VSTAT_B_EXT;
		if (do_rd)
		begin
			// unimplemented slots and bits read as zero
			case (sp)
				R_STAT: s_next.rdata = {rc.ext_lat[2],
					rc.eom_latch & ~rc.eom_shown_clr, rc.ext_lat[1], 1'b0, rc.ext_lat[0],
					tx_buf_empty[host_chan_a], 1'b0, rx_char_avail[host_chan_a]};
				R_SPEC: s_next.rdata = spec_status[host_chan_a];
				R_VEC: s_next.rdata = host_chan_a ? s_reg.vector
					: {s_reg.vector[7:4], vcode, s_reg.vector[0]};
				R_PEND: s_next.rdata = host_chan_a ? {2'b00, rx_ip[CH_A], tx_ip[CH_A], s_reg.ch[CH_A].ext_pend,
					rx_ip[CH_B], tx_ip[CH_B], s_reg.ch[CH_B].ext_pend} : 8'h00;
				R_MODE_RB: s_next.rdata = rc.efr[EXT_READ_BIT] ? rc.wr4 : 8'h00;
				R_TXCTL_RB: s_next.rdata = rc.efr[EXT_READ_BIT] ? rc.wr5 : 8'h00;
				R_FCNT_LO: s_next.rdata = (is_sdlc(rc) && rc.wr15[FIFO_EN_BIT])
					? fifo_count[host_chan_a][7:0] : 8'h00;
				R_FCNT_HI: s_next.rdata = (is_sdlc(rc) && rc.wr15[FIFO_EN_BIT])
					? {fifo_flags[host_chan_a], fifo_count[host_chan_a][13:8]} : 8'h00;
				R_RXDATA: s_next.rdata = rx_data[host_chan_a];
				R_RXCTL_RB: s_next.rdata = rc.efr[EXT_READ_BIT] ? rc.wr3 : 8'h00;
				R_MISC_RB: s_next.rdata = rc.efr[EXT_READ_BIT] ? rc.wr10 : 8'h00;
				R_TCLO: s_next.rdata = rc.wr12;
				R_TCHI: s_next.rdata = rc.wr13;
				R_PRIME_RB: s_next.rdata = rc.efr;
				R_EXTEN_RB: s_next.rdata = rc.wr15;
				default: s_next.rdata = 8'h00;
			endcase
		end
		if (do_wr && sp == W_VECTOR)
			s_next.vector = host_wdata;
		if (mres)
			s_next.master = host_wdata;
		for (int i = 0; i < 2; i++)
		begin
			c = s_reg.ch[i];
			wc = do_wr && (host_chan_a == 1'(i));
			cmd = wc && sp == W_CMD;
			ch_rst = mres && (host_wdata[7:6] == MRST_HW || host_wdata[7:6] == (i == CH_A ? MRST_CH_A : MRST_CH_B));
			c.append_crc = 1'b0;
			c.send_abort = 1'b0;
			// pointer falls back to zero after each access, except a command write, which loads it
			if ((do_wr || do_rd) && host_chan_a == 1'(i))
				c.ptr = 4'h0;
			if (cmd)
				c.ptr = {host_wdata[5:3] == CMD_POINT_HIGH, host_wdata[2:0]};
			if (wc)
			begin
				case (sp)
					W_RXCTL: c.wr3 = host_wdata;
					W_MODE: c.wr4 = host_wdata;
					W_TXCTL: c.wr5 = host_wdata;
					W_PRIME: if (s_reg.ch[i].wr15[PRIME_SEL_BIT]) c.efr = host_wdata;
					W_MISC: c.wr10 = host_wdata;
					W_TCLO: c.wr12 = host_wdata;
					W_TCHI: c.wr13 = host_wdata;
					W_EXTEN: c.wr15 = host_wdata;
					default: ;
				endcase
			end
			if (rx_bit_vld[i])
				c.rx_crc = crc_step(s_reg.ch[i].rx_crc, rx_bit[i]);
			if (tx_bit_vld[i])
				c.tx_crc = crc_step(s_reg.ch[i].tx_crc, tx_bit[i]);
			// code 00 falls through every branch below
			if (cmd && host_wdata[7:6] == CRC_RX_RST)
				c.rx_crc = CRC_PRESET;
			if (wc && sp == W_RXCTL && !host_wdata[RXEN_BIT])
				c.rx_crc = CRC_PRESET;
			if (is_sdlc(s_reg.ch[i]) && sdlc_frame_end[i])
				c.rx_crc = CRC_PRESET;
			if (cmd && host_wdata[7:6] == CRC_TX_RST)
				c.tx_crc = CRC_PRESET;
			if (s_reg.ch[i].efr[AUTO_EOM_BIT] && tx_crc_done[i])
				c.tx_crc = CRC_PRESET;
			// status change latches until released; a late change re-arms next cycle
			if (cmd && host_wdata[5:3] == CMD_EXT_RST)
			begin
				c.ext_pend = 1'b0;
				c.eom_shown_clr = 1'b0;
			end
			if (!s_reg.ch[i].ext_pend)
			begin
				c.ext_lat = ext_in[i];
				if (ext_in[i] != s_reg.ch[i].ext_lat)
					c.ext_pend = 1'b1;
			end
			if (cmd && host_wdata[7:6] == CRC_EOM_RST)
			begin
				if (s_reg.ch[i].wr5[TXEN_BIT])
					c.eom_latch = 1'b0;
				else if (!s_reg.ch[i].ext_pend || host_wdata[5:3] == CMD_EXT_RST)
				begin
					c.ext_pend = 1'b1;
					c.eom_shown_clr = 1'b1;
				end
			end
			if (cmd && host_wdata[5:3] == CMD_SEND_ABORT)
				c.eom_latch = 1'b1;
			// underrun with latch clear starts crc or abort; the set wins over a clear
			if (tx_underrun[i] && !s_reg.ch[i].eom_latch)
			begin
				c.eom_latch = 1'b1;
				if (is_sdlc(s_reg.ch[i]) && s_reg.ch[i].wr10[ABORT_UR_BIT])
					c.send_abort = 1'b1;
				else
					c.append_crc = 1'b1;
			end
			if (ch_rst)
				c = chan_init(c, 1'b1);
			s_next.ch[i] = c;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			s_reg.ch[CH_A] <= chan_init('0, 1'b0);
			s_reg.ch[CH_B] <= chan_init('0, 1'b0);
			s_reg.vector <= RST_REG8;
			s_reg.master <= RST_REG8;
			s_reg.rdata <= RST_REG8;
			s_reg.rvalid <= 1'b0;
		end
		else
			s_reg <= s_next;
	end

	assign host_rdata = s_reg.rdata;
	assign host_rdata_valid = s_reg.rvalid;
	assign append_crc = {s_reg.ch[CH_A].append_crc, s_reg.ch[CH_B].append_crc};
	assign send_abort = {s_reg.ch[CH_A].send_abort, s_reg.ch[CH_B].send_abort};
	assign ext_irq = {s_reg.ch[CH_A].ext_pend, s_reg.ch[CH_B].ext_pend};
	assign rx_crc = {s_reg.ch[CH_A].rx_crc, s_reg.ch[CH_B].rx_crc};
	assign tx_crc = {s_reg.ch[CH_A].tx_crc, s_reg.ch[CH_B].tx_crc};

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	logic cmd_a;
	logic txen_a;
	logic abort_mode_a;
	assign cmd_a = do_wr && host_chan_a && sp == W_CMD;
	assign txen_a = s_reg.ch[CH_A].wr5[TXEN_BIT];
	assign abort_mode_a = is_sdlc(s_reg.ch[CH_A]) && s_reg.ch[CH_A].wr10[ABORT_UR_BIT];

	sequence point_high_a_seq;
		cmd_a && host_wdata[5:3] == CMD_POINT_HIGH && host_wdata[2:0] == 3'h4;
	endsequence
	sequence read_a_seq;
		do_rd && host_chan_a;
	endsequence

	crc_null_a: assert property (cmd_a && host_wdata[7:6] == CRC_NULL && !rx_bit_vld[CH_A] && !tx_bit_vld[CH_A]
		&& !sdlc_frame_end[CH_A] && !tx_crc_done[CH_A] |=> $stable(rx_crc[CH_A]) && $stable(tx_crc[CH_A]))
		else $error("null crc code changed a crc");
	rx_crc_cmd_a: assert property (cmd_a && host_wdata[7:6] == CRC_RX_RST |=> rx_crc[CH_A] == CRC_PRESET)
		else $error("receive checker not initialised");
	rx_disable_a: assert property (do_wr && host_chan_a && sp == W_RXCTL && !host_wdata[RXEN_BIT]
		|=> rx_crc[CH_A] == CRC_PRESET) else $error("receiver disable kept checker");
	tx_crc_cmd_a: assert property (cmd_a && host_wdata[7:6] == CRC_TX_RST |=> tx_crc[CH_A] == CRC_PRESET)
		else $error("transmit generator not initialised");
	chan_rst_keep_a: assert property (mres && host_wdata[7:6] == MRST_CH_A && !tx_bit_vld[CH_A] && !tx_crc_done[CH_A]
		|=> $stable(tx_crc[CH_A]) && !ext_irq[CH_A]) else $error("channel reset disturbed generator");
	underrun_crc_a: assert property (tx_underrun[CH_A] && !s_reg.ch[CH_A].eom_latch && !abort_mode_a
		|=> append_crc[CH_A] && !send_abort[CH_A] ##1 !append_crc[CH_A]) else $error("underrun did not append crc");
	underrun_abort_a: assert property (tx_underrun[CH_A] && !s_reg.ch[CH_A].eom_latch && abort_mode_a
		|=> send_abort[CH_A] && !append_crc[CH_A] && s_reg.ch[CH_A].eom_latch) else $error("no abort on underrun");
	latch_hold_a: assert property (cmd_a && host_wdata[7:6] == CRC_EOM_RST && !txen_a && !tx_underrun[CH_A]
		|=> s_reg.ch[CH_A].eom_latch == $past(s_reg.ch[CH_A].eom_latch)) else $error("latch cleared while disabled");
	eom_irq_a: assert property (cmd_a && host_wdata[7:6] == CRC_EOM_RST && !txen_a && !ext_irq[CH_A]
		|=> ext_irq[CH_A] && s_reg.ch[CH_A].eom_shown_clr) else $error("no status interrupt on latch reset");
	ext_release_a: assert property (cmd_a && host_wdata[5:3] == CMD_EXT_RST && host_wdata[7:6] != CRC_EOM_RST
		&& ext_in[CH_A] == s_reg.ch[CH_A].ext_lat |=> !ext_irq[CH_A]) else $error("status not released");
	vec_raw_a: assert property (read_a_seq ##0 (sp == R_VEC) |=> host_rdata_valid && host_rdata == s_reg.vector)
		else $error("channel A vector modified");
	pend_b_zero_a: assert property (do_rd && !host_chan_a && sp == R_PEND |=> host_rdata == 8'h00)
		else $error("channel B pending register not zero");
	vec_shared_a: assert property (do_wr && !host_chan_a && sp == W_VECTOR |=> s_reg.vector == $past(host_wdata))
		else $error("vector write through B lost");
	point_high_a: assert property (point_high_a_seq ##1 read_a_seq |=> host_rdata == s_reg.ch[CH_A].wr12)
		else $error("point high read wrong register");
endmodule

// [test/scrcc_host.sv]
/*
 * Host cpu model: byte writes and reads, with pointer setup.
 * Assumes a free-running mclk and read data one cycle after the read.
 */
`timescale 1ns/1ps
module scrcc_host
	import scrcc_pkg::*;
(
	// clock
	input wire logic mclk,
	// host register port
	output logic host_cs,
	output logic host_chan_a,
	output logic host_wr,
	output logic host_rd,
	output logic [7:0] host_wdata,
	input wire logic [7:0] host_rdata,
	input wire logic host_rdata_valid
);
	initial
	begin
		{host_cs, host_chan_a, host_wr, host_rd} = 4'h0;
		host_wdata = 8'h00;
	end
	task automatic put(input logic ch, input logic w, input logic r, input logic [7:0] d);
		@(posedge mclk);
		#1;
		host_cs = w | r;
		host_chan_a = ch;
		host_wr = w;
		host_rd = r;
		host_wdata = d;
	endtask
	task automatic point(input logic ch, input logic [3:0] slot);
		if (slot != 4'h0)
		begin
			put(ch, 1'b1, 1'b0, {2'b00, slot[3] ? CMD_POINT_HIGH : 3'h0, slot[2:0]});
		end
	endtask
	task automatic wr(input logic ch, input logic [3:0] slot, input logic [7:0] d);
		point(ch, slot);
		put(ch, 1'b1, 1'b0, d);
		// released data shows the inverse
		put(ch, 1'b0, 1'b0, ~d);
	endtask
	task automatic rd(input logic ch, input logic [3:0] slot, output logic [7:0] q);
		point(ch, slot);
		put(ch, 1'b0, 1'b1, 8'h00);
		put(ch, 1'b0, 1'b0, 8'hff);
		q = (host_rdata_valid === 1'b1) ? host_rdata : 8'hxx;
	endtask
	task automatic cmd(input logic ch, input logic [1:0] crc, input logic [2:0] code);
		wr(ch, 4'h0, {crc, code, 3'h0});
	endtask
endmodule

// [test/scrcc_regs_tb.sv]
/*
 * Self-checking bench for the register bank and crc/end-of-message control.
 * Assumes the host model drives the bus; datapath events are driven here.
 */
`timescale 1ns/1ps
module scrcc_regs_tb
	import scrcc_pkg::*;
;
	typedef struct packed {logic ch; logic [3:0] ws; logic [7:0] wd; logic [3:0] rs; logic [7:0] ex;} scrcc_row_s;
	localparam logic [15:0] ONE_STEP = 16'hefdf;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic host_cs, host_chan_a, host_wr, host_rd, host_rdata_valid;
	logic [7:0] host_wdata, host_rdata, q;
	logic [1:0] rx_bit_vld = 2'b00, rx_bit = 2'b00, tx_bit_vld = 2'b00, tx_bit = 2'b00;
	logic [1:0] tx_underrun = 2'b00, tx_crc_done = 2'b00, sdlc_frame_end = 2'b00;
	logic [1:0] rx_char_avail = 2'b10, tx_buf_empty = 2'b10, rx_ip = 2'b10, tx_ip = 2'b01;
	logic [1:0][2:0] ext_in = '0;
	logic [1:0][7:0] rx_data = 16'hc300, spec_status = 16'h3c00;
	logic [1:0][13:0] fifo_count = 28'h48d0000;
	logic [1:0][1:0] fifo_flags = 4'h0;
	logic [1:0] append_crc, send_abort, ext_irq;
	logic [1:0][15:0] rx_crc, tx_crc;
	logic [5:0] s;
	int fail_count = 0;
	int checks_done = 0;
	scrcc_row_s rows [17] = '{
		'{1'b1, 4'hc, 8'h5a, 4'hc, 8'h5a}, '{1'b0, 4'hd, 8'ha5, 4'hd, 8'ha5},
		'{1'b1, 4'h2, 8'h80, 4'h2, 8'h80}, '{1'b0, 4'h2, 8'h90, 4'h2, 8'h96},
		'{1'b1, 4'h0, 8'h00, 4'h3, 8'h22}, '{1'b0, 4'h0, 8'h00, 4'h3, 8'h00},
		'{1'b1, 4'h4, 8'h20, 4'h6, 8'h00}, '{1'b1, 4'hf, 8'h04, 4'h6, 8'h34},
		'{1'b1, 4'h0, 8'h00, 4'h4, 8'h00}, '{1'b1, 4'hf, 8'h05, 4'he, 8'h00},
		'{1'b1, 4'h7, 8'h40, 4'h4, 8'h20}, '{1'b1, 4'ha, 8'h04, 4'hb, 8'h04},
		'{1'b0, 4'h0, 8'h00, 4'hb, 8'h00}, '{1'b1, 4'h0, 8'h00, 4'h1, 8'h3c},
		'{1'b1, 4'h0, 8'h00, 4'h8, 8'hc3}, '{1'b1, 4'h0, 8'h00, 4'ha, 8'h00},
		'{1'b1, 4'h0, 8'h00, 4'h0, 8'h45}};
	always #12.5 mclk = ~mclk;
	scrcc_host host (.mclk(mclk), .host_cs(host_cs), .host_chan_a(host_chan_a), .host_wr(host_wr),
		.host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rdata_valid(host_rdata_valid));
	scrcc_regs dut (.mclk(mclk), .sys_rst(sys_rst), .host_cs(host_cs), .host_chan_a(host_chan_a),
		.host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
		.host_rdata_valid(host_rdata_valid), .rx_bit_vld(rx_bit_vld), .rx_bit(rx_bit), .tx_bit_vld(tx_bit_vld),
		.tx_bit(tx_bit), .tx_underrun(tx_underrun), .tx_crc_done(tx_crc_done), .sdlc_frame_end(sdlc_frame_end),
		.rx_char_avail(rx_char_avail), .tx_buf_empty(tx_buf_empty), .rx_ip(rx_ip), .tx_ip(tx_ip),
		.ext_in(ext_in), .rx_data(rx_data), .spec_status(spec_status), .fifo_count(fifo_count),
		.fifo_flags(fifo_flags), .append_crc(append_crc), .send_abort(send_abort), .ext_irq(ext_irq),
		.rx_crc(rx_crc), .tx_crc(tx_crc));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done = checks_done + 1;
		if (got !== exp)
		begin
			fail_count = fail_count + 1;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// pulses last one cycle; outputs gathered over two
	task automatic watch();
		s = 6'h00;
		repeat (2)
		begin
			@(posedge mclk);
			#1;
			{rx_bit_vld, tx_bit_vld, tx_underrun, tx_crc_done, sdlc_frame_end} = 10'h000;
			s = s | {append_crc, send_abort, ext_irq};
		end
	endtask
	task automatic close_out();
		if (fail_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		#(4000 * 25);
		fail_count = fail_count + 1;
		close_out();
	end
	initial
	begin
		repeat (6) @(posedge mclk);
		#1;
		sys_rst = 1'b0;
		chk(16'({append_crc, send_abort, ext_irq, host_rdata_valid, host_rdata}), 16'h0000);
		chk(tx_crc[1] & tx_crc[0] & rx_crc[1] & rx_crc[0], CRC_PRESET);
		for (int i = 0; i < 17; i++)
		begin
			host.wr(rows[i].ch, rows[i].ws, rows[i].wd);
			host.rd(rows[i].ch, rows[i].rs, q);
			chk(16'(q), 16'(rows[i].ex));
		end
		ext_in[1] = 3'h1;
		watch();
		chk(16'(s[1]), 16'h0001);
		host.rd(1'b0, R_VEC, q);
		chk(16'(q), 16'h009a);
		host.rd(1'b1, R_VEC, q);
		chk(16'(q), 16'h0090);
		host.cmd(1'b1, CRC_NULL, CMD_EXT_RST);
		chk(16'(ext_irq[1]), 16'h0000);
		rx_bit_vld = 2'b10;
		watch();
		host.cmd(1'b1, CRC_NULL, 3'h0);
		chk(rx_crc[1], ONE_STEP);
		host.cmd(1'b1, CRC_RX_RST, 3'h0);
		chk(rx_crc[1], CRC_PRESET);
		rx_bit_vld = 2'b10;
		watch();
		host.wr(1'b1, W_RXCTL, 8'h00);
		chk(rx_crc[1], CRC_PRESET);
		rx_bit_vld = 2'b10;
		watch();
		sdlc_frame_end = 2'b10;
		watch();
		chk(rx_crc[1], CRC_PRESET);
		tx_bit_vld = 2'b10;
		watch();
		host.cmd(1'b1, CRC_TX_RST, 3'h0);
		chk(tx_crc[1], CRC_PRESET);
		tx_bit_vld = 2'b10;
		watch();
		host.wr(1'b1, W_PRIME, 8'h42);
		tx_crc_done = 2'b10;
		watch();
		chk(tx_crc[1], CRC_PRESET);
		tx_bit_vld = 2'b10;
		watch();
		host.wr(1'b0, W_MASTER, {MRST_CH_A, 6'h00});
		chk(tx_crc[1], ONE_STEP);
		host.rd(1'b1, R_TCLO, q);
		chk(16'(q), 16'h0000);
		host.wr(1'b1, W_TXCTL, 8'h08);
		host.cmd(1'b1, CRC_TX_RST, CMD_EXT_RST);
		tx_underrun = 2'b10;
		watch();
		chk(16'(s[5]), 16'h0000);
		host.cmd(1'b1, CRC_EOM_RST, 3'h0);
		host.rd(1'b1, R_STAT, q);
		chk(16'(q[ST_EOM]), 16'h0000);
		tx_underrun = 2'b10;
		watch();
		chk(16'({s[5], s[3]}), 16'h0002);
		host.rd(1'b1, R_STAT, q);
		chk(16'(q[ST_EOM]), 16'h0001);
		host.wr(1'b1, W_MODE, 8'h20);
		host.wr(1'b1, W_MISC, 8'h04);
		host.cmd(1'b1, CRC_EOM_RST, 3'h0);
		tx_underrun = 2'b10;
		watch();
		chk(16'({s[5], s[3]}), 16'h0001);
		host.wr(1'b1, W_TXCTL, 8'h00);
		host.cmd(1'b1, CRC_EOM_RST, 3'h0);
		chk(16'(ext_irq[1]), 16'h0001);
		host.rd(1'b1, R_STAT, q);
		chk(16'(q[ST_EOM]), 16'h0000);
		tx_underrun = 2'b10;
		watch();
		chk(16'({s[5], s[3]}), 16'h0000);
		host.cmd(1'b1, CRC_EOM_RST, CMD_EXT_RST);
		chk(16'(ext_irq[1]), 16'h0001);
		close_out();
	end
endmodule
